//--- shared/tsr_defs.svh
// Purpose: Register offsets, field positions and reset values of the timing signal router
// Assumes: Byte addresses on an 8-bit AXI4-Lite address
// Notes:   Definitions only
`ifndef TSR_DEFS_SVH
`define TSR_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TSR_OFF_PFI_OE   8'h00
`define TSR_OFF_PFI_POL  8'h04
`define TSR_OFF_PFI_EDGE 8'h08
`define TSR_OFF_BUS_OE   8'h0c
`define TSR_OFF_TB_CTRL  8'h10
`define TSR_OFF_DED_OE   8'h14
`define TSR_OFF_STATUS   8'h18
`define TSR_OFF_BUS_SEL  8'h20
`define TSR_OFF_DEST_SEL 8'h40
`define TSR_OFF_END      8'h80
// ----------------------------------------
// Fields, sizes and source codes
// ----------------------------------------
`define TSR_NUM_PFI      10
`define TSR_NUM_BUS      7
`define TSR_NUM_DEST     16
`define TSR_NUM_INT      8
`define TSR_NUM_DED      5
`define TSR_STAR_LINE    6
`define TSR_SRC_BUS0     5'h0a
`define TSR_SRC_INT0     5'h11
`define TSR_SRC_CNT      5'h19
`define TSR_TB_EXT_BIT   0
`define TSR_TB_DRV_BIT   1
`define TSR_STAT_BUS_LSB 10
// ----------------------------------------
// Reset values and responses
// ----------------------------------------
`define TSR_RST_DEST_SEL 5'h11
`define TSR_RST_BUS_SEL  4'h0
`define TSR_RESP_OKAY    2'b00
`define TSR_RESP_SLVERR  2'b10
`endif

//--- shared/tsr_pkg.sv
// Purpose: Types shared by the timing signal router
// Assumes: tsr_defs.svh sizes
// Notes:   Function pin and trigger bus outputs travel as packed structs
`include "tsr_defs.svh"
package tsr_pkg;
  typedef logic [4:0] tsr_sel_t;
  typedef logic [3:0] tsr_bsel_t;
  // Destination index of each selectable internal timing signal
  typedef enum logic [3:0] {
    TSR_D_AI_START = 4'h0, TSR_D_AI_REF = 4'h1, TSR_D_AI_PAUSE = 4'h2, TSR_D_AI_SAMPLE = 4'h3,
    TSR_D_AI_CONVERT = 4'h4, TSR_D_AI_SAMPLE_TB = 4'h5, TSR_D_AO_START = 4'h6, TSR_D_AO_PAUSE = 4'h7,
    TSR_D_AO_SAMPLE = 4'h8, TSR_D_AO_SAMPLE_TB = 4'h9, TSR_D_C0_SRC = 4'ha, TSR_D_C0_GATE = 4'hb,
    TSR_D_C0_UPDOWN = 4'hc, TSR_D_C1_SRC = 4'hd, TSR_D_C1_GATE = 4'he, TSR_D_C1_UPDOWN = 4'hf
  } tsr_dest_t;
  typedef struct packed {
    logic [`TSR_NUM_PFI-1:0] drv;
    logic [`TSR_NUM_PFI-1:0] oe_n;
  } tsr_pfi_out_t;
  typedef struct packed {
    logic [`TSR_NUM_BUS-1:0] drv;
    logic [`TSR_NUM_BUS-1:0] oe_n;
    logic                    clk_drv;
    logic                    clk_oe_n;
  } tsr_bus_out_t;
endpackage : tsr_pkg

//--- verilog/tsr_router.sv
// Purpose: Timing signal router between function pins, trigger bus and internal timing signals
// Assumes: aclk is the root timebase domain; pin inputs synchronous to aclk
// Notes:   AXI4-Lite register slave, one write and one read at a time
`timescale 1ns/1ns
`include "tsr_defs.svh"
module tsr_router #(
  parameter bit HAS_BUS   = 1'b1,
  parameter bit BACKPLANE = 1'b0
) (
  input  wire  logic                             aclk,
  input  wire  logic                             aresetn,
  input  wire  logic [7:0]                       s_axi_awaddr,
  input  wire  logic                             s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire  logic [31:0]                      s_axi_wdata,
  input  wire  logic [3:0]                       s_axi_wstrb,
  input  wire  logic                             s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire  logic                             s_axi_bready,
  input  wire  logic [7:0]                       s_axi_araddr,
  input  wire  logic                             s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire  logic                             s_axi_rready,
  input  wire  logic [`TSR_NUM_PFI-1:0]          prog_function_pin_in,
  output tsr_pkg::tsr_pfi_out_t                  prog_function_pin_out,
  input  wire  logic [`TSR_NUM_BUS-1:0]          board_sync_trigger_bus_in,
  input  wire  logic                             board_sync_clk_in,
  output tsr_pkg::tsr_bus_out_t                  board_sync_trigger_bus_out,
  input  wire  logic [`TSR_NUM_PFI-1:0]          export_sig,
  input  wire  logic [`TSR_NUM_DED-1:0]          dedicated_sig,
  output logic [`TSR_NUM_DED-1:0]                dedicated_out,
  output logic [`TSR_NUM_DED-1:0]                dedicated_oe_n,
  input  wire  logic [`TSR_NUM_INT-1:0]          internal_sig,
  input  wire  logic                             fast_internal_timebase,
  output logic [`TSR_NUM_DEST-1:0]               timing_out,
  output logic                                   root_timebase
);
  import tsr_pkg::*;

  // ----------------------------------------
  // Configuration storage
  // ----------------------------------------
  logic [`TSR_NUM_PFI-1:0] pfi_oe;
  logic [`TSR_NUM_PFI-1:0] pfi_pol;
  logic [`TSR_NUM_PFI-1:0] pfi_edge;
  logic [`TSR_NUM_BUS-1:0] bus_oe;
  logic [1:0]              tb_ctrl;
  logic [`TSR_NUM_DED-1:0] ded_oe;
  tsr_bsel_t               bus_sel  [`TSR_NUM_BUS];
  tsr_sel_t                dest_sel [`TSR_NUM_DEST];
  logic [7:0]              aw_addr;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    do_write;
  logic [`TSR_NUM_PFI-1:0] pfi_cond;
  logic [`TSR_NUM_PFI-1:0] pfi_prev;
  logic [`TSR_SRC_CNT-1:0] src_pool;
  logic [`TSR_NUM_BUS-1:0] bus_allow;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Any aligned word below the end of the map is decoded
  function automatic logic mapped(input logic [7:0] a);
    return (a < `TSR_OFF_END) && (a[1:0] == 2'b00);
  endfunction : mapped

  // Readback of one register word, unused bits zero
  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `TSR_OFF_PFI_OE:   r[`TSR_NUM_PFI-1:0] = pfi_oe;
      `TSR_OFF_PFI_POL:  r[`TSR_NUM_PFI-1:0] = pfi_pol;
      `TSR_OFF_PFI_EDGE: r[`TSR_NUM_PFI-1:0] = pfi_edge;
      `TSR_OFF_BUS_OE:   r[`TSR_NUM_BUS-1:0] = bus_oe;
      `TSR_OFF_TB_CTRL:  r[1:0] = tb_ctrl;
      `TSR_OFF_DED_OE:   r[`TSR_NUM_DED-1:0] = ded_oe;
      `TSR_OFF_STATUS: begin
        r[`TSR_NUM_PFI-1:0] = prog_function_pin_in;
        r[`TSR_STAT_BUS_LSB +: `TSR_NUM_BUS] = board_sync_trigger_bus_in;
      end
      default: begin
        if (a >= `TSR_OFF_DEST_SEL && a < `TSR_OFF_END) begin
          r[4:0] = dest_sel[a[5:2]];
        end else if (a >= `TSR_OFF_BUS_SEL && a < `TSR_OFF_BUS_SEL + 8'h1c) begin
          r[3:0] = bus_sel[a[4:2]];
        end
      end
    endcase
    return r;
  endfunction : read_word

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  // Address and data are held until both are in; response two cycles after the later one
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TSR_RESP_OKAY;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) ? `TSR_RESP_OKAY : `TSR_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  // Data is captured at the address handshake, so it stands unchanged while rvalid waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TSR_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= read_word(s_axi_araddr);
        s_axi_rresp   <= mapped(s_axi_araddr) ? `TSR_RESP_OKAY : `TSR_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Register updates
  // ----------------------------------------
  // Reset leaves every driver off and the internal timebase in use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pfi_oe   <= '0;
      pfi_pol  <= '0;
      pfi_edge <= '0;
      bus_oe   <= '0;
      tb_ctrl  <= 2'b00;
      ded_oe   <= '0;
      for (int i = 0; i < `TSR_NUM_BUS; i++) begin
        bus_sel[i] <= `TSR_RST_BUS_SEL;
      end
      for (int d = 0; d < `TSR_NUM_DEST; d++) begin
        dest_sel[d] <= `TSR_RST_DEST_SEL;
      end
    end else if (do_write) begin
      case (aw_addr)
        `TSR_OFF_PFI_OE:   pfi_oe   <= 10'(merge(32'(pfi_oe), w_data, w_strb));
        `TSR_OFF_PFI_POL:  pfi_pol  <= 10'(merge(32'(pfi_pol), w_data, w_strb));
        `TSR_OFF_PFI_EDGE: pfi_edge <= 10'(merge(32'(pfi_edge), w_data, w_strb));
        `TSR_OFF_BUS_OE:   bus_oe   <= 7'(merge(32'(bus_oe), w_data, w_strb)) & bus_allow;
        `TSR_OFF_TB_CTRL:  tb_ctrl  <= 2'(merge(32'(tb_ctrl), w_data, w_strb));
        `TSR_OFF_DED_OE:   ded_oe   <= 5'(merge(32'(ded_oe), w_data, w_strb));
        default: begin
          if (aw_addr >= `TSR_OFF_DEST_SEL && aw_addr < `TSR_OFF_END) begin
            dest_sel[aw_addr[5:2]] <= tsr_sel_t'(merge(32'(dest_sel[aw_addr[5:2]]), w_data, w_strb));
          end else if (aw_addr >= `TSR_OFF_BUS_SEL && aw_addr < `TSR_OFF_BUS_SEL + 8'h1c) begin
            bus_sel[aw_addr[4:2]] <= tsr_bsel_t'(merge(32'(bus_sel[aw_addr[4:2]]), w_data, w_strb));
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Input conditioning and source pool
  // ----------------------------------------
  // Star line is receive only on the backplane; without a bus nothing may drive
  always_comb begin
    bus_allow = HAS_BUS ? {`TSR_NUM_BUS{1'b1}} : '0;
    if (BACKPLANE) begin
      bus_allow[`TSR_STAR_LINE] = 1'b0;
    end
  end

  // Edge mode yields a one-cycle pulse on the active edge; level mode passes the level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pfi_prev <= '0;
      pfi_cond <= '0;
    end else begin
      pfi_prev <= prog_function_pin_in ^ pfi_pol;
      for (int i = 0; i < `TSR_NUM_PFI; i++) begin
        pfi_cond[i] <= pfi_edge[i] ? ((prog_function_pin_in[i] ^ pfi_pol[i]) & ~pfi_prev[i])
                                   : (prog_function_pin_in[i] ^ pfi_pol[i]);
      end
    end
  end

  // Pool codes: pins 0-9, bus lines 0-6, then internal signals; internal 0 is reference clock,
  // internal 1 the counter-0 terminal output. A bus-less build's pool sees its bus inputs as zero; the status register reads them raw.
  assign src_pool = {internal_sig, board_sync_trigger_bus_in & {`TSR_NUM_BUS{HAS_BUS}}, pfi_cond};

  // ----------------------------------------
  // Timing signal multiplexers
  // ----------------------------------------
  // Out-of-range codes give a quiet low rather than an arbitrary input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timing_out <= '0;
    end else begin
      for (int d = 0; d < `TSR_NUM_DEST; d++) begin
        timing_out[d] <= (dest_sel[d] < `TSR_SRC_CNT) ? src_pool[dest_sel[d]] : 1'b0;
      end
    end
  end

  // Root timebase never looks at a function pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      root_timebase <= 1'b0;
    end else begin
      root_timebase <= (tb_ctrl[`TSR_TB_EXT_BIT] && HAS_BUS) ? board_sync_clk_in : fast_internal_timebase;
    end
  end

  // ----------------------------------------
  // Pin and bus drivers
  // ----------------------------------------
  // Pin i exports only export_sig[i]; pin 8 carries the counter-0 source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_function_pin_out.drv  <= '0;
      prog_function_pin_out.oe_n <= '1;
      dedicated_out              <= '0;
      dedicated_oe_n             <= '1;
    end else begin
      prog_function_pin_out.drv  <= export_sig;
      prog_function_pin_out.oe_n <= ~pfi_oe;
      dedicated_out              <= dedicated_sig;
      dedicated_oe_n             <= ~ded_oe;
    end
  end

  // Bus lines drive any internal signal; clock line only carries our own internal timebase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      board_sync_trigger_bus_out <= '{drv: '0, oe_n: '1, clk_drv: 1'b0, clk_oe_n: 1'b1};
    end else begin
      for (int i = 0; i < `TSR_NUM_BUS; i++) begin
        board_sync_trigger_bus_out.drv[i] <= internal_sig[bus_sel[i][2:0]];
      end
      board_sync_trigger_bus_out.oe_n     <= ~(bus_oe & bus_allow);
      board_sync_trigger_bus_out.clk_drv  <= fast_internal_timebase;
      board_sync_trigger_bus_out.clk_oe_n <= ~(HAS_BUS && tb_ctrl[`TSR_TB_DRV_BIT]
                                              && !tb_ctrl[`TSR_TB_EXT_BIT]);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_pfi_export;
    @(posedge aclk) disable iff (!aresetn) pfi_oe[8] |=> !prog_function_pin_out.oe_n[8]
      && prog_function_pin_out.drv[8] == $past(export_sig[8]);
  endproperty
  a_pfi_export: assert property (p_pfi_export) else $error("pin 8 not exporting");
  property p_pfi_off;
    @(posedge aclk) disable iff (!aresetn) !pfi_oe[3] |=> prog_function_pin_out.oe_n[3];
  endproperty
  a_pfi_off: assert property (p_pfi_off) else $error("pin driven while disabled");
  property p_star;
    @(posedge aclk) disable iff (!aresetn) BACKPLANE |-> board_sync_trigger_bus_out.oe_n[`TSR_STAR_LINE];
  endproperty
  a_star: assert property (p_star) else $error("star line driven");
  property p_nobus;
    @(posedge aclk) disable iff (!aresetn) !HAS_BUS |-> &board_sync_trigger_bus_out.oe_n
      && board_sync_trigger_bus_out.clk_oe_n;
  endproperty
  a_nobus: assert property (p_nobus) else $error("bus driven without bus");
  property p_start;
    @(posedge aclk) $rose(aresetn) |-> &prog_function_pin_out.oe_n && &dedicated_oe_n
      && board_sync_trigger_bus_out.clk_oe_n && tb_ctrl == 2'b00;
  endproperty
  a_start: assert property (p_start) else $error("outputs active after reset");
  property p_root;
    @(posedge aclk) disable iff (!aresetn) (HAS_BUS && tb_ctrl[`TSR_TB_EXT_BIT])
      |=> root_timebase == $past(board_sync_clk_in);
  endproperty
  a_root: assert property (p_root) else $error("root timebase wrong source");
  property p_root_int;
    @(posedge aclk) disable iff (!aresetn) !tb_ctrl[`TSR_TB_EXT_BIT]
      |=> root_timebase == $past(fast_internal_timebase);
  endproperty
  a_root_int: assert property (p_root_int) else $error("root timebase not internal");
  property p_convert;
    @(posedge aclk) disable iff (!aresetn) dest_sel[TSR_D_AI_CONVERT] == `TSR_SRC_BUS0
      && $stable(dest_sel[TSR_D_AI_CONVERT]) |=> timing_out[TSR_D_AI_CONVERT] == $past(src_pool[10]);
  endproperty
  a_convert: assert property (p_convert) else $error("convert clock not from bus line 0");
  property p_edge;
    @(posedge aclk) disable iff (!aresetn) pfi_cond[5] && $past(pfi_edge[5]) && pfi_edge[5] |=> !pfi_cond[5];
  endproperty
  a_edge: assert property (p_edge) else $error("edge pulse longer than a cycle");
  property p_bresp;
    @(posedge aclk) disable iff (!aresetn) s_axi_wvalid && s_axi_wready && (!s_axi_awready || s_axi_awvalid)
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response late");
  c_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
  c_ext_tb: cover property (@(posedge aclk) tb_ctrl[`TSR_TB_EXT_BIT]);
  c_pin_drive: cover property (@(posedge aclk) !prog_function_pin_out.oe_n[8]);
endmodule : tsr_router

//--- bench/tsr_far_side.sv
// Purpose: Outside circuitry facing the function pins and the trigger bus
// Assumes: The bench sets the levels the outside world offers
// Notes:   A line shows the device value only while its driver is enabled
`timescale 1ns/1ns
module tsr_far_side (
  input  wire tsr_pkg::tsr_pfi_out_t pfi_out,
  input  wire tsr_pkg::tsr_bus_out_t bus_out,
  input  wire logic [9:0]            ext_pfi,
  input  wire logic [6:0]            ext_bus,
  input  wire logic                  ext_clk,
  output logic [9:0]                 pfi_wire,
  output logic [6:0]                 bus_wire,
  output logic                       clk_wire
);
  import tsr_pkg::*;
  // ----------------------------------------
  // Wire levels
  // ----------------------------------------
  // Outside drive yields wherever the device enables its driver, so no contention
  assign pfi_wire = (~pfi_out.oe_n & pfi_out.drv) | (pfi_out.oe_n & ext_pfi);
  assign bus_wire = (~bus_out.oe_n & bus_out.drv) | (bus_out.oe_n & ext_bus);
  assign clk_wire = bus_out.clk_oe_n ? ext_clk : bus_out.clk_drv;
endmodule : tsr_far_side

//--- bench/testbench.sv
// Purpose: Self-checking bench for the timing signal router
// Assumes: Backplane build with the trigger bus present
// Notes:   Registers reached through AXI4-Lite tasks
`timescale 1ns/1ns
`include "tsr_defs.svh"
module testbench;
  import tsr_pkg::*;
  logic         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [7:0]   awaddr, araddr, int_sig;
  logic [31:0]  wdata, rdata, rd;
  logic [1:0]   bresp, rresp, rs;
  logic [9:0]   ext_pfi, pfi_wire, export_sig;
  logic [6:0]   ext_bus, bus_wire;
  logic         ext_clk, clk_wire, fast_tb, root_tb;
  logic [4:0]   ded_sig, ded_out, ded_oe_n;
  logic [15:0]  timing;
  tsr_pfi_out_t pfi_out;
  tsr_bus_out_t bus_out;
  int           miscompares, n_compared, hits, k;

  // Clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  tsr_router #(.HAS_BUS(1'b1), .BACKPLANE(1'b1)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .prog_function_pin_in(pfi_wire),
    .prog_function_pin_out(pfi_out), .board_sync_trigger_bus_in(bus_wire), .board_sync_clk_in(clk_wire),
    .board_sync_trigger_bus_out(bus_out), .export_sig(export_sig), .dedicated_sig(ded_sig),
    .dedicated_out(ded_out), .dedicated_oe_n(ded_oe_n), .internal_sig(int_sig),
    .fast_internal_timebase(fast_tb), .timing_out(timing), .root_timebase(root_tb));

  tsr_far_side far_u (.pfi_out(pfi_out), .bus_out(bus_out), .ext_pfi(ext_pfi), .ext_bus(ext_bus),
    .ext_clk(ext_clk), .pfi_wire(pfi_wire), .bus_wire(bus_wire), .clk_wire(clk_wire));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task complete_run;
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Three edges cover the two-edge pin path; reads at the edge see the settled values
  task settle;
    repeat (3) @(posedge aclk);
  endtask : settle

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (i == 64) begin
      miscompares++;
      complete_run;
    end
    chk(32'(bresp), 32'(er));
  endtask : wr

  task rd_reg(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
    if (i == 64) begin
      miscompares++;
      complete_run;
    end
  endtask : rd_reg

  // ----------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------
  initial begin
    #200000;
    miscompares++;
    complete_run;
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, ext_clk, fast_tb} = '0;
    {awaddr, araddr, wdata, ext_pfi, ext_bus, export_sig, ded_sig, int_sig} = '0;
    miscompares = 0;
    n_compared  = 0;
    aresetn     = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    chk(pfi_out.oe_n, 10'h3ff);
    chk({bus_out.oe_n, bus_out.clk_oe_n, ded_oe_n}, 13'h1fff);
    rd_reg(`TSR_OFF_DEST_SEL);
    chk(rd, 32'(`TSR_RST_DEST_SEL));
    // Every pin and bus line, and internal sources 0 and 1, reach the convert clock
    for (k = 0; k < 17; k++) begin
      wr(`TSR_OFF_DEST_SEL + 8'h10, 32'(k), `TSR_RESP_OKAY);
      @(posedge aclk);
      {ext_bus, ext_pfi} <= 17'h1 << k;
      settle;
      chk(timing[TSR_D_AI_CONVERT], 1'b1);
    end
    {ext_bus, ext_pfi} <= '0;
    for (k = 0; k < 2; k++) begin
      wr(`TSR_OFF_DEST_SEL + 8'h10, 32'(`TSR_SRC_INT0 + k), `TSR_RESP_OKAY);
      @(posedge aclk);
      int_sig <= 8'h1 << k;
      settle;
      chk(timing[TSR_D_AI_CONVERT], 1'b1);
    end
    // A code past the last source must leave the signal quiet
    wr(`TSR_OFF_DEST_SEL + 8'h10, 32'(`TSR_SRC_CNT), `TSR_RESP_OKAY);
    int_sig <= 8'hff;
    settle;
    chk(timing[TSR_D_AI_CONVERT], 1'b0);
    for (k = 0; k < 16; k++) wr(`TSR_OFF_DEST_SEL + 8'(4 * k), 32'h5, `TSR_RESP_OKAY);
    ext_pfi <= 10'h020;
    settle;
    chk(timing, 16'hffff);
    ext_pfi <= 10'h000;
    wr(`TSR_OFF_PFI_POL, 32'h20, `TSR_RESP_OKAY);
    settle;
    chk(timing, 16'hffff);
    // Edge mode gives a single-cycle pulse on a held level
    wr(`TSR_OFF_PFI_POL, 32'h0, `TSR_RESP_OKAY);
    wr(`TSR_OFF_PFI_EDGE, 32'h20, `TSR_RESP_OKAY);
    ext_pfi <= 10'h020;
    hits = 0;
    repeat (6) begin
      @(posedge aclk);
      if (timing[0] === 1'b1) hits++;
    end
    chk(hits, 1);
    // Exports and input status
    ext_pfi <= 10'h000;
    ext_bus <= 7'h55;
    export_sig <= 10'h3ff;
    wr(`TSR_OFF_PFI_OE, 32'h100, `TSR_RESP_OKAY);
    settle;
    chk(pfi_out.oe_n, 10'h2ff);
    chk(pfi_wire, 10'h100);
    rd_reg(`TSR_OFF_STATUS);
    chk(rd, {15'h0, 7'h55, 10'h100});
    wr(`TSR_OFF_STATUS, 32'hffffffff, `TSR_RESP_OKAY);
    wr(`TSR_OFF_DED_OE, 32'h1f, `TSR_RESP_OKAY);
    ded_sig <= 5'h15;
    settle;
    chk({ded_oe_n, ded_out}, 10'h015);
    // Star line stays receive only on the backplane build
    ext_bus <= 7'h00;
    int_sig <= 8'h02;
    wr(`TSR_OFF_BUS_SEL, 32'h1, `TSR_RESP_OKAY);
    wr(`TSR_OFF_BUS_OE, 32'h7f, `TSR_RESP_OKAY);
    rd_reg(`TSR_OFF_BUS_OE);
    chk(rd, 32'h3f);
    settle;
    chk(bus_out.oe_n, 7'h40);
    chk(bus_wire[0], 1'b1);
    // Root timebase choice and the clock line driver
    fast_tb <= 1'b1;
    settle;
    chk(root_tb, 1'b1);
    wr(`TSR_OFF_TB_CTRL, 32'h2, `TSR_RESP_OKAY);
    settle;
    chk(bus_out.clk_oe_n, 1'b0);
    chk(clk_wire, 1'b1);
    wr(`TSR_OFF_TB_CTRL, 32'h1, `TSR_RESP_OKAY);
    ext_pfi <= 10'h3ff;
    settle;
    chk({bus_out.clk_oe_n, root_tb}, 2'b10);
    ext_clk <= 1'b1;
    settle;
    chk(root_tb, 1'b1);
    // Unmapped place answers with an error and reads zero
    wr(`TSR_OFF_END, 32'h1, `TSR_RESP_SLVERR);
    rd_reg(`TSR_OFF_END);
    chk({30'h0, rs}, 32'(`TSR_RESP_SLVERR));
    chk(rd, 32'h0);
    complete_run;
  end
endmodule : testbench
